/* File: rtl/adc_seq_pkg.sv */
package adc_seq_pkg;
  localparam int unsigned chan_w = 4;
  localparam int unsigned result_w = 10;
  localparam int unsigned num_results = 12;
  localparam int unsigned conv_time_ns = 1000;
  localparam int unsigned clock_period_ns = 10;
  localparam int unsigned conv_cycles = (conv_time_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int unsigned conv_cnt_w = 8;
  localparam logic [1:0] scan_len_4 = 2'h0;
  localparam logic [1:0] scan_len_8 = 2'h1;
  localparam logic [1:0] scan_len_12 = 2'h2;
  localparam logic [1:0] irq_every_1 = 2'h0;
  localparam logic [1:0] irq_every_4 = 2'h1;
  localparam logic [1:0] irq_every_8 = 2'h2;
  localparam logic [3:0] group_4_mask = 4'hc;
  localparam logic [chan_w-1:0] chan_reset = 4'h0;
  localparam logic [result_w-1:0] result_reset = 10'h000;
  typedef enum logic [1:0] {st_idle, st_normal, st_prio} seq_state_e;
endpackage

/* File: rtl/adc_sequence_priority_control.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Fixed mode converts chan_select only
// - Scan group from chan_select and length
// - Start bits launch normal or priority conversion
// - Priority is always fixed single conversion
// - Source select: 0 pin fall, 1 timer
// - Hardware starts need their enable bit
// - Software starts work with hardware enabled
// - Starts set matching busy flag, except a normal start while priority runs or starts
// - Priority start keeps normal busy and done
// - Priority pre-empts normal, then normal resumes
// - Interrupted channel is reconverted on resume
// - Repeat cleared: finish current, drop busy
// - Fixed single: done, not busy, interrupt
// - Scan single: done after whole scan
// - Fixed repeat: busy stays, done at interval
// - Scan repeat: done each pass, busy stays
// - Priority end: irq, done, result stored
// - Result valid when stored and not overrun
// - Reading done flags clears them
// - Priority start during priority is ignored
// - Repeat interval 1, 4 or 8 results
module adc_sequence_priority_control
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Mode configuration
  input wire logic scan_sel,
  input wire logic repeat_sel,
  input wire logic [chan_w-1:0] chan_select,
  input wire logic [1:0] scan_length_sel,
  input wire logic [1:0] repeat_irq_interval,
  input wire logic [chan_w-1:0] prio_chan_select,
  // Start sources
  input wire logic normal_start,
  input wire logic prio_start,
  input wire logic soft_reset_cmd,
  input wire logic normal_hw_src_sel,
  input wire logic prio_hw_src_sel,
  input wire logic normal_hw_trig_en,
  input wire logic prio_hw_trig_en,
  input wire logic ext_trigger_pin,
  input wire logic timer_match,
  // Converter core
  output logic [chan_w-1:0] analog_input,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [result_w-1:0] conv_data,
  // Status
  output logic normal_busy,
  output logic prio_busy,
  output logic normal_done,
  output logic prio_done,
  input wire logic normal_done_read,
  input wire logic prio_done_read,
  output logic normal_done_irq,
  output logic prio_done_irq,
  // Results
  input wire logic [3:0] result_index,
  input wire logic result_read,
  output logic [result_w-1:0] result_reg,
  output logic result_stored,
  output logic result_overrun,
  output logic result_valid,
  output logic [result_w-1:0] prio_result_reg
);

  // ----------------------------------------
  // Trigger synchroniser and edges
  // ----------------------------------------
  logic trig_sync1_reg, trig_sync1_next;
  logic trig_sync2_reg, trig_sync2_next;
  logic trig_prev_reg, trig_prev_next;
  logic pin_fall, hw_normal, hw_prio, go_normal, go_prio;

  always_comb begin
    trig_sync1_next = ext_trigger_pin;
    trig_sync2_next = trig_sync1_reg;
    trig_prev_next = trig_sync2_reg;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      trig_sync1_reg <= 1'b1;
      trig_sync2_reg <= 1'b1;
      trig_prev_reg <= 1'b1;
    end else begin
      trig_sync1_reg <= trig_sync1_next;
      trig_sync2_reg <= trig_sync2_next;
      trig_prev_reg <= trig_prev_next;
    end
  end

  assign pin_fall = trig_prev_reg & ~trig_sync2_reg;
  assign hw_normal = normal_hw_trig_en & (normal_hw_src_sel ? timer_match : pin_fall);
  assign hw_prio = prio_hw_trig_en & (prio_hw_src_sel ? timer_match : pin_fall);
  assign go_normal = normal_start | hw_normal;
  assign go_prio = prio_start | hw_prio;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_state_e state_reg, state_next;
  logic [chan_w-1:0] cur_chan_reg, cur_chan_next;
  logic [chan_w-1:0] first_chan_reg, first_chan_next;
  logic [chan_w-1:0] last_chan_reg, last_chan_next;
  logic [2:0] rep_cnt_reg, rep_cnt_next;
  logic scan_reg, scan_next;
  logic nbusy_reg, nbusy_next;
  logic pbusy_reg, pbusy_next;
  logic ndone_reg, ndone_next;
  logic pdone_reg, pdone_next;
  logic nirq_reg, nirq_next;
  logic pirq_reg, pirq_next;
  logic cstart_reg, cstart_next;
  logic [chan_w-1:0] ain_reg, ain_next;
  logic [result_w-1:0] presult_reg, presult_next;
  logic [result_w-1:0] res_mem_reg [num_results];
  logic [result_w-1:0] res_mem_next [num_results];
  logic [num_results-1:0] stored_reg, stored_next;
  logic [num_results-1:0] ovr_reg, ovr_next;
  logic [chan_w-1:0] grp_first, grp_last, store_idx;
  logic [2:0] rep_limit;
  logic set_ndone, set_pdone;

  // Scan group bounds
  always_comb begin
    grp_first = chan_reset;
    grp_last = chan_select;
    if (scan_length_sel == scan_len_4) begin
      grp_first = chan_select & group_4_mask;
    end
  end

  always_comb begin
    case (repeat_irq_interval)
      irq_every_4: rep_limit = 3'h3;
      irq_every_8: rep_limit = 3'h7;
      default: rep_limit = 3'h0;
    endcase
  end

  // Fixed repeat fills registers in turn, else indexed by channel
  assign store_idx = (!scan_reg && repeat_sel) ? {1'b0, rep_cnt_reg} : cur_chan_reg;

  always_comb begin
    state_next = state_reg;
    cur_chan_next = cur_chan_reg;
    first_chan_next = first_chan_reg;
    last_chan_next = last_chan_reg;
    rep_cnt_next = rep_cnt_reg;
    scan_next = scan_reg;
    nbusy_next = nbusy_reg;
    pbusy_next = pbusy_reg;
    nirq_next = 1'b0;
    pirq_next = 1'b0;
    cstart_next = 1'b0;
    ain_next = ain_reg;
    presult_next = presult_reg;
    res_mem_next = res_mem_reg;
    stored_next = stored_reg;
    ovr_next = ovr_reg;
    set_ndone = 1'b0;
    set_pdone = 1'b0;
    if (result_read && result_index < 4'hc) begin
      stored_next[result_index] = 1'b0;
      ovr_next[result_index] = 1'b0;
    end
    case (state_reg)
      st_idle: begin
        if (go_prio) begin
          state_next = st_prio;
          pbusy_next = 1'b1;
          ain_next = prio_chan_select;
          cstart_next = 1'b1;
        end else if (go_normal) begin
          state_next = st_normal;
          nbusy_next = 1'b1;
          scan_next = scan_sel;
          rep_cnt_next = 3'h0;
          first_chan_next = scan_sel ? grp_first : chan_select;
          last_chan_next = scan_sel ? grp_last : chan_select;
          cur_chan_next = scan_sel ? grp_first : chan_select;
          ain_next = scan_sel ? grp_first : chan_select;
          cstart_next = 1'b1;
        end
      end
      st_normal: begin
        if (go_prio) begin
          // Suspend; current channel kept for reconversion
          state_next = st_prio;
          pbusy_next = 1'b1;
          ain_next = prio_chan_select;
          cstart_next = 1'b1;
        end else if (conv_done) begin
          if (stored_reg[store_idx] && !(result_read && result_index == store_idx)) begin
            ovr_next[store_idx] = 1'b1;
          end
          stored_next[store_idx] = 1'b1;
          res_mem_next[store_idx] = conv_data;
          if (!scan_reg && !repeat_sel) begin
            set_ndone = 1'b1;
            nbusy_next = 1'b0;
            nirq_next = 1'b1;
            state_next = st_idle;
          end else if (!scan_reg) begin
            rep_cnt_next = (rep_cnt_reg == rep_limit) ? 3'h0 : rep_cnt_reg + 3'h1;
            if (rep_cnt_reg == rep_limit) begin
              set_ndone = 1'b1;
              nirq_next = 1'b1;
            end
            cstart_next = 1'b1;
          end else if (cur_chan_reg == last_chan_reg) begin
            set_ndone = 1'b1;
            nirq_next = 1'b1;
            cur_chan_next = first_chan_reg;
            ain_next = first_chan_reg;
            if (repeat_sel) begin
              cstart_next = 1'b1;
            end else begin
              nbusy_next = 1'b0;
              state_next = st_idle;
            end
          end else begin
            cur_chan_next = cur_chan_reg + 4'h1;
            ain_next = cur_chan_reg + 4'h1;
            cstart_next = 1'b1;
          end
        end
      end
      st_prio: begin
        // Further priority starts ignored
        if (conv_done) begin
          presult_next = conv_data;
          set_pdone = 1'b1;
          pirq_next = 1'b1;
          pbusy_next = 1'b0;
          if (nbusy_reg) begin
            state_next = st_normal;
            ain_next = cur_chan_reg;
            cstart_next = 1'b1;
          end else begin
            state_next = st_idle;
          end
        end
      end
      default: state_next = st_idle;
    endcase
    if (soft_reset_cmd) begin
      state_next = st_idle;
      nbusy_next = 1'b0;
      pbusy_next = 1'b0;
      cstart_next = 1'b0;
    end
  end

  // Set wins over read clear
  assign ndone_next = set_ndone | (ndone_reg & ~normal_done_read);
  assign pdone_next = set_pdone | (pdone_reg & ~prio_done_read);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= st_idle;
      cur_chan_reg <= chan_reset;
      first_chan_reg <= chan_reset;
      last_chan_reg <= chan_reset;
      rep_cnt_reg <= 3'h0;
      scan_reg <= 1'b0;
      nbusy_reg <= 1'b0;
      pbusy_reg <= 1'b0;
      ndone_reg <= 1'b0;
      pdone_reg <= 1'b0;
      nirq_reg <= 1'b0;
      pirq_reg <= 1'b0;
      cstart_reg <= 1'b0;
      ain_reg <= chan_reset;
      presult_reg <= result_reset;
      res_mem_reg <= '{default: result_reset};
      stored_reg <= '0;
      ovr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cur_chan_reg <= cur_chan_next;
      first_chan_reg <= first_chan_next;
      last_chan_reg <= last_chan_next;
      rep_cnt_reg <= rep_cnt_next;
      scan_reg <= scan_next;
      nbusy_reg <= nbusy_next;
      pbusy_reg <= pbusy_next;
      ndone_reg <= ndone_next;
      pdone_reg <= pdone_next;
      nirq_reg <= nirq_next;
      pirq_reg <= pirq_next;
      cstart_reg <= cstart_next;
      ain_reg <= ain_next;
      presult_reg <= presult_next;
      res_mem_reg <= res_mem_next;
      stored_reg <= stored_next;
      ovr_reg <= ovr_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign analog_input = ain_reg;
  assign conv_start = cstart_reg;
  assign normal_busy = nbusy_reg;
  assign prio_busy = pbusy_reg;
  assign normal_done = ndone_reg;
  assign prio_done = pdone_reg;
  assign normal_done_irq = nirq_reg;
  assign prio_done_irq = pirq_reg;
  assign prio_result_reg = presult_reg;
  assign result_reg = (result_index < 4'hc) ? res_mem_reg[result_index] : result_reset;
  assign result_stored = (result_index < 4'hc) ? stored_reg[result_index] : 1'b0;
  assign result_overrun = (result_index < 4'hc) ? ovr_reg[result_index] : 1'b0;
  assign result_valid = result_stored & ~result_overrun;

endmodule

/* File: dv/adc_core_model.sv */
`timescale 1ns/1ns
module adc_core_model
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Converter handshake
  input wire logic [chan_w-1:0] analog_input,
  input wire logic conv_start,
  input wire logic [3:0] lat,
  output logic conv_done,
  output logic [result_w-1:0] conv_data
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  logic [chan_w-1:0] chan_reg;
  // Any start restarts, pre-emption too
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      chan_reg <= 4'h0;
    end else if (conv_start) begin
      busy_reg <= 1'b1;
      cnt_reg <= lat;
      chan_reg <= analog_input;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      busy_reg <= 1'b0;
    end
  end
  assign conv_done = busy_reg && cnt_reg == 4'h0 && !conv_start;
  assign conv_data = conv_done ? {chan_reg, chan_reg, 2'h1} : ~{chan_reg, chan_reg, 2'h1};
endmodule

/* File: dv/adc_seq_properties.sv */
`timescale 1ns/1ns
module adc_seq_properties
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Controls
  input wire logic scan_sel,
  input wire logic repeat_sel,
  input wire logic [chan_w-1:0] prio_chan_select,
  input wire logic normal_start,
  input wire logic prio_start,
  input wire logic soft_reset_cmd,
  input wire logic normal_done_read,
  // Converter and status
  input wire logic [chan_w-1:0] analog_input,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [result_w-1:0] conv_data,
  input wire logic normal_busy,
  input wire logic prio_busy,
  input wire logic normal_done,
  input wire logic prio_done,
  input wire logic normal_done_irq,
  input wire logic prio_done_irq,
  input wire logic result_stored,
  input wire logic result_overrun,
  input wire logic result_valid,
  input wire logic [result_w-1:0] prio_result_reg
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire idle = !normal_busy && !prio_busy;
  sequence s_norm_end;
    ##1 normal_done && normal_done_irq && !normal_busy;
  endsequence
  sequence s_prio_end;
    ##1 prio_done && prio_done_irq && !prio_busy && prio_result_reg == $past(conv_data);
  endsequence
  a_normal_start_busy: assert property (normal_start && idle && !soft_reset_cmd |=> normal_busy && conv_start)
    else $error("normal start not taken");
  a_prio_start_chan: assert property (prio_start && !prio_busy && !soft_reset_cmd
    |=> prio_busy && conv_start && analog_input == $past(prio_chan_select))
    else $error("priority start wrong");
  a_prio_keeps_normal: assert property (prio_start && !prio_busy && !conv_done && !normal_done_read && !soft_reset_cmd
    |=> $stable(normal_busy) && $stable(normal_done))
    else $error("normal flags disturbed");
  a_prio_start_ignored: assert property (prio_busy && prio_start && !conv_done && !soft_reset_cmd
    |=> prio_busy && !conv_start)
    else $error("second priority start taken");
  a_prio_end_result: assert property (prio_busy && conv_done && !soft_reset_cmd |-> s_prio_end)
    else $error("priority end wrong");
  a_fixed_single_end: assert property (normal_busy && !prio_busy && !scan_sel && !repeat_sel && conv_done
    && !soft_reset_cmd |-> s_norm_end)
    else $error("fixed single end wrong");
  a_repeat_keeps_busy: assert property (normal_done_irq && repeat_sel && $past(repeat_sel)
    |-> normal_busy && normal_done)
    else $error("repeat busy dropped");
  a_result_valid_flag: assert property (result_valid == (result_stored && !result_overrun))
    else $error("result valid wrong");
  a_done_read_clear: assert property (normal_done_read && !conv_done |=> !normal_done)
    else $error("done not cleared");
endmodule

/* File: dv/adc_sequence_priority_control_tb_top.sv */
`timescale 1ns/1ns
module adc_sequence_priority_control_tb_top;
  import adc_seq_pkg::*;
  logic clock, sys_rst, scan_sel, repeat_sel, conv_start, conv_done, result_stored, result_overrun, result_valid;
  logic normal_hw_src_sel, prio_hw_src_sel, normal_hw_trig_en, prio_hw_trig_en, ext_trigger_pin;
  logic normal_busy, prio_busy, normal_done, prio_done, normal_done_irq, prio_done_irq;
  logic [chan_w-1:0] chan_select, prio_chan_select, analog_input;
  logic [1:0] scan_length_sel, repeat_irq_interval;
  logic [3:0] result_index, lat;
  logic [result_w-1:0] conv_data, result_reg, prio_result_reg;
  logic [6:0] kick;
  wire normal_start = kick[0];
  wire prio_start = kick[1];
  wire soft_reset_cmd = kick[2];
  wire timer_match = kick[3];
  wire normal_done_read = kick[4];
  wire prio_done_read = kick[5];
  wire result_read = kick[6];
  wire [3:0] stat = {prio_done, normal_done, prio_busy, normal_busy};
  int fail_count, cmp_count, dn_cnt, lo, n;
  int exp_c[6];
  logic [chan_w-1:0] seen_q[$];
  adc_sequence_priority_control DUT (
    .clock(clock), .sys_rst(sys_rst), .scan_sel(scan_sel), .repeat_sel(repeat_sel),
    .chan_select(chan_select), .scan_length_sel(scan_length_sel),
    .repeat_irq_interval(repeat_irq_interval), .prio_chan_select(prio_chan_select),
    .normal_start(normal_start), .prio_start(prio_start), .soft_reset_cmd(soft_reset_cmd),
    .normal_hw_src_sel(normal_hw_src_sel), .prio_hw_src_sel(prio_hw_src_sel),
    .normal_hw_trig_en(normal_hw_trig_en), .prio_hw_trig_en(prio_hw_trig_en),
    .ext_trigger_pin(ext_trigger_pin), .timer_match(timer_match),
    .analog_input(analog_input), .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
    .normal_busy(normal_busy), .prio_busy(prio_busy), .normal_done(normal_done), .prio_done(prio_done),
    .normal_done_read(normal_done_read), .prio_done_read(prio_done_read),
    .normal_done_irq(normal_done_irq), .prio_done_irq(prio_done_irq),
    .result_index(result_index), .result_read(result_read), .result_reg(result_reg),
    .result_stored(result_stored), .result_overrun(result_overrun), .result_valid(result_valid),
    .prio_result_reg(prio_result_reg)
  );
  adc_core_model core (
    .clock(clock), .sys_rst(sys_rst), .analog_input(analog_input), .conv_start(conv_start), .lat(lat),
    .conv_done(conv_done), .conv_data(conv_data)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (conv_start === 1'b1) seen_q.push_back(analog_input);
    if (conv_done === 1'b1) dn_cnt++;
  end
  function automatic logic [result_w-1:0] f(input logic [chan_w-1:0] c);
    return {c, c, 2'h1};
  endfunction
  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [result_w-1:0] got, input logic [result_w-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_until(input int b, input logic v);
    n = 0;
    while ((b < 4 ? stat[b] : seen_q.size() > 2) !== v) begin
      @(negedge clock);
      n++;
      if (n > 3000) begin
        fail_count++;
        test_done();
      end
    end
  endtask
  task automatic pulse(input int b);
    @(posedge clock);
    kick <= 7'(1 << b);
    @(posedge clock);
    kick <= 7'h0;
  endtask
  task automatic mode(input logic s, input logic r, input logic [3:0] c, input logic [1:0] l);
    @(posedge clock);
    scan_sel <= s;
    repeat_sel <= r;
    chan_select <= c;
    scan_length_sel <= l;
    repeat_irq_interval <= l;
  endtask
  task automatic run(input int b);
    pulse(b);
    wait_until(2, 1'b1);
    pulse(4);
    @(negedge clock);
    check(10'(stat[2]), 10'h0);
  endtask
  task automatic rd(input int i, input logic [1:0] fl);
    @(posedge clock);
    result_index <= 4'(i);
    @(negedge clock);
    check(result_reg, f(4'(i)));
    check(10'(result_stored), 10'(fl[1] | fl[0]));
    check(10'({result_valid, result_overrun}), 10'(fl));
  endtask
  initial begin
    void'($urandom(32'h39ec));
    sys_rst = 1'b1;
    kick = 7'h0;
    {scan_sel, repeat_sel, normal_hw_src_sel, prio_hw_src_sel, normal_hw_trig_en, prio_hw_trig_en} = 6'h0;
    ext_trigger_pin = 1'b1;
    {chan_select, prio_chan_select, scan_length_sel, repeat_irq_interval, result_index} = 16'h0;
    lat = 4'h2;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    lo = $urandom_range(11, 0);
    lat <= 4'($urandom_range(7, 1));
    mode(0, 0, 4'(lo), 2'h0);
    run(0);
    check(10'(seen_q.pop_front()), 10'(lo));
    check(10'(stat), 10'h0);
    rd(lo, 2'b10);
    run(0);
    rd(lo, 2'b01);
    pulse(6);
    lat <= 4'hf;
    pulse(0);
    pulse(2);
    @(negedge clock);
    check(10'(stat[0]), 10'h0);
    run(0);
    seen_q.delete();
    for (int l = 0; l < 3; l++) begin
      lo = $urandom_range(7, 0);
      mode(1, 0, 4'(lo), 2'(l));
      run(0);
      for (int c = (l == 0) ? (lo & 12) : 0; c <= lo; c++) check(10'(seen_q.pop_front()), 10'(c));
    end
    check(10'(seen_q.size()), 10'h0);
    lo = $urandom_range(11, 4);
    mode(1, 1, 4'h3, 2'h0);
    prio_chan_select <= 4'(lo);
    lat <= 4'h6;
    pulse(0);
    wait_until(4, 1'b1);
    pulse(1);
    pulse(1);
    wait_until(3, 1'b1);
    check(prio_result_reg, f(4'(lo)));
    check(10'(stat), 10'h9);
    wait_until(2, 1'b1);
    check(10'(stat[0]), 10'h1);
    @(posedge clock);
    repeat_sel <= 1'b0;
    wait_until(0, 1'b0);
    exp_c = '{0, 1, 2, lo, 2, 3};
    foreach (exp_c[i]) check(10'(seen_q[i]), 10'(exp_c[i]));
    pulse(5);
    pulse(4);
    @(negedge clock);
    check(10'(stat), 10'h0);
    lat <= 4'h3;
    for (int l = 0; l < 3; l++) begin
      dn_cnt = 0;
      mode(0, 1, 4'h5, 2'(l));
      pulse(0);
      wait_until(2, 1'b1);
      check(10'(dn_cnt), 10'(l == 0 ? 1 : 4 * l));
      check(10'(stat[0]), 10'h1);
      @(posedge clock);
      repeat_sel <= 1'b0;
      wait_until(0, 1'b0);
      pulse(4);
    end
    mode(0, 0, 4'h2, 2'h0);
    normal_hw_src_sel <= 1'b1;
    pulse(3);
    repeat (2) @(negedge clock);
    check(10'(stat[0]), 10'h0);
    @(posedge clock);
    normal_hw_trig_en <= 1'b1;
    run(3);
    run(0);
    @(posedge clock);
    prio_hw_trig_en <= 1'b1;
    ext_trigger_pin <= 1'b0;
    repeat (4) @(posedge clock);
    ext_trigger_pin <= 1'b1;
    wait_until(3, 1'b1);
    check(prio_result_reg, f(prio_chan_select));
    pulse(5);
    normal_hw_trig_en <= 1'b0;
    prio_hw_src_sel <= 1'b1;
    pulse(3);
    wait_until(3, 1'b1);
    check(10'(stat), 10'h8);
    check(prio_result_reg, f(prio_chan_select));
    test_done();
  end
endmodule
bind adc_sequence_priority_control adc_seq_properties chk (
  .clock(clock), .sys_rst(sys_rst), .scan_sel(scan_sel), .repeat_sel(repeat_sel),
  .prio_chan_select(prio_chan_select), .normal_start(normal_start), .prio_start(prio_start),
  .soft_reset_cmd(soft_reset_cmd), .normal_done_read(normal_done_read), .analog_input(analog_input),
  .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
  .normal_busy(normal_busy), .prio_busy(prio_busy), .normal_done(normal_done), .prio_done(prio_done),
  .normal_done_irq(normal_done_irq), .prio_done_irq(prio_done_irq),
  .result_stored(result_stored), .result_overrun(result_overrun), .result_valid(result_valid),
  .prio_result_reg(prio_result_reg)
);
